/* File: rtl/bpi_pkg.sv */
// Package for the boot progress indicator: port address, code classes, pattern timing.
// Assumes a 40 MHz system clock; durations are given in ms here and converted to cycle counts in the indicator.
package bpi_pkg;
    localparam int CLK_HZ = 40000000;
    localparam logic [15:0] PROGRESS_PORT_ADDR = 16'h0080;
    localparam logic [7:0] PROGRESS_RESET = 8'h00;
    localparam int TONE_MAIN_HZ = 932;
    localparam int TONE_HIGH_HZ = 2000;
    localparam int TONE_LOW_HZ = 1500;
    localparam int TONE_MAIN_HALF = CLK_HZ / (2 * TONE_MAIN_HZ);
    localparam int TONE_HIGH_HALF = CLK_HZ / (2 * TONE_HIGH_HZ);
    localparam int TONE_LOW_HALF = CLK_HZ / (2 * TONE_LOW_HZ);
    localparam int PROMPT_MS = 500;
    localparam int PULSE_MS = 1000;
    localparam int PAUSE_MS = 2500;
    localparam int BLINK_MS = 250;
    localparam int UPDATE_MS = 500;
    localparam int VIDEO_BEEPS = 2;
    localparam int MEMORY_BEEPS = 3;
    localparam int VIDEO_TONE_ROUNDS = 2;
    localparam int THERMAL_TONES = 8;
    localparam logic [7:0] CODE_BOOT_FAIL = 8'hEF;
    localparam logic [7:0] CODE_CPU_EXCEPTION = 8'hFF;
    localparam logic [3:0] FATAL_LOW_NIBBLE = 4'hF;

    typedef enum logic [3:0] {
        BPI_CAT_DEBUG, BPI_CAT_CPU, BPI_CAT_MEMORY, BPI_CAT_RECOVERY, BPI_CAT_BUS,
        BPI_CAT_OUTPUT, BPI_CAT_INPUT, BPI_CAT_BOOT_MEDIA, BPI_CAT_BOOT_SELECT,
        BPI_CAT_MISC, BPI_CAT_RESERVED
    } bpi_category_t;

    typedef enum logic [2:0] {
        BPI_PAT_IDLE, BPI_PAT_PROMPT, BPI_PAT_UPDATE, BPI_PAT_VIDEO, BPI_PAT_MEMORY, BPI_PAT_THERMAL
    } bpi_pattern_t;

    typedef struct packed {
        logic prompt;
        logic updateStart;
        logic updateDone;
        logic videoFault;
        logic memoryFault;
        logic thermalTrip;
    } bpi_request_t;

    typedef struct packed {
        logic [6:0] segHigh;
        logic [6:0] segLow;
    } bpi_display_t;
endpackage

/* File: rtl/bpi_indicator.sv */
// Boot progress indicator: progress code latch, code classifier, beep and LED patterns.
// Assumes host I/O writes and pattern requests arrive synchronous to clk as one-cycle strobes.
//
// Overview of operation
// - Prompt request gives one 0.5 s 932 Hz tone.
// - Video fault: two beeps, pause, twice, stop.
// - Memory fault: three beeps, pause, forever.
// - Thermal: eight alternating high/low tones, then shutdown.
// - Update: speaker silent, LED off then toggles.
// - Video fault LED: two blinks, pause, forever.
// - Memory fault LED: three blinks, pause, forever.
// - Thermal: two quarter-second blinks per tone.
// - Latch last code written to PROGRESS_PORT_ADDR.
// - Show held code as two hex digits.
// - Classify held code by upper hex digit.
// - Flag xF codes as fatal, except in debug, boot select, misc and reserved classes.
// - EF boot failure, FF exception, E0-EE benign.
`timescale 1ns/100ps
module bpi_indicator
    import bpi_pkg::*;
#(
    parameter int CLK_RATE = CLK_HZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [15:0] ioAddr,
    input wire logic [7:0] ioWdata,
    input wire bpi_request_t request,
    output logic [7:0] ioRdata,
    output logic [7:0] heldCode,
    output bpi_display_t display,
    output bpi_category_t category,
    output logic fatalError,
    output logic bootFail,
    output logic cpuException,
    output logic speaker,
    output logic powerLed,
    output logic shutdownReq,
    output logic patternBusy
);
    localparam int MS_CYC = CLK_RATE / 1000;
    localparam logic [27:0] PROMPT_CYC = 28'(PROMPT_MS * MS_CYC);
    localparam logic [27:0] PULSE_CYC = 28'(PULSE_MS * MS_CYC);
    localparam logic [27:0] PAUSE_CYC = 28'(PAUSE_MS * MS_CYC);
    localparam logic [27:0] BLINK_CYC = 28'(BLINK_MS * MS_CYC);
    localparam logic [27:0] UPDATE_CYC = 28'(UPDATE_MS * MS_CYC);
    localparam logic [15:0] MAIN_HALF = 16'(CLK_RATE / (2 * TONE_MAIN_HZ));
    localparam logic [15:0] HIGH_HALF = 16'(CLK_RATE / (2 * TONE_HIGH_HZ));
    localparam logic [15:0] LOW_HALF = 16'(CLK_RATE / (2 * TONE_LOW_HZ));

    function automatic logic [6:0] hex_to_seg(input logic [3:0] nib);
        case (nib)
            4'h0: hex_to_seg = 7'h3F;
            4'h1: hex_to_seg = 7'h06;
            4'h2: hex_to_seg = 7'h5B;
            4'h3: hex_to_seg = 7'h4F;
            4'h4: hex_to_seg = 7'h66;
            4'h5: hex_to_seg = 7'h6D;
            4'h6: hex_to_seg = 7'h7D;
            4'h7: hex_to_seg = 7'h07;
            4'h8: hex_to_seg = 7'h7F;
            4'h9: hex_to_seg = 7'h6F;
            4'hA: hex_to_seg = 7'h77;
            4'hB: hex_to_seg = 7'h7C;
            4'hC: hex_to_seg = 7'h39;
            4'hD: hex_to_seg = 7'h5E;
            4'hE: hex_to_seg = 7'h79;
            default: hex_to_seg = 7'h71;
        endcase
    endfunction

    function automatic bpi_category_t classify(input logic [3:0] hi);
        case (hi)
            4'h0: classify = BPI_CAT_DEBUG;
            4'h1: classify = BPI_CAT_CPU;
            4'h2: classify = BPI_CAT_MEMORY;
            4'h3: classify = BPI_CAT_RECOVERY;
            4'h5: classify = BPI_CAT_BUS;
            4'h7: classify = BPI_CAT_OUTPUT;
            4'h9: classify = BPI_CAT_INPUT;
            4'hB: classify = BPI_CAT_BOOT_MEDIA;
            4'hD: classify = BPI_CAT_BOOT_SELECT;
            4'hE, 4'hF: classify = BPI_CAT_MISC;
            default: classify = BPI_CAT_RESERVED;
        endcase
    endfunction

    logic [7:0] code_reg;
    logic hit;
    bpi_category_t catNext;
    logic fatalNext;
    assign hit = (ioAddr == PROGRESS_PORT_ADDR);
    assign catNext = classify(code_reg[7:4]);
    assign fatalNext = (code_reg[3:0] == FATAL_LOW_NIBBLE) && (catNext != BPI_CAT_RESERVED)
        && (catNext != BPI_CAT_DEBUG) && (catNext != BPI_CAT_BOOT_SELECT) && (catNext != BPI_CAT_MISC);

    // The code is held across a halt because nothing but reset or a new write touches it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            code_reg <= PROGRESS_RESET;
        end else if (ioWrite && hit) begin
            code_reg <= ioWdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ioRdata <= 8'h00;
        end else if (ioRead && hit) begin
            ioRdata <= code_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            heldCode <= PROGRESS_RESET;
            display <= '0;
            category <= BPI_CAT_DEBUG;
            fatalError <= 1'b0;
            bootFail <= 1'b0;
            cpuException <= 1'b0;
        end else begin
            heldCode <= code_reg;
            display.segHigh <= hex_to_seg(code_reg[7:4]);
            display.segLow <= hex_to_seg(code_reg[3:0]);
            category <= catNext;
            fatalError <= fatalNext;
            bootFail <= (code_reg == CODE_BOOT_FAIL);
            cpuException <= (code_reg == CODE_CPU_EXCEPTION);
        end
    end

    // Pattern sequencer: a phase counter runs down one phase; step index counts on, off and pause phases, round index counts rounds.
    bpi_pattern_t pat_reg;
    logic [27:0] phaseCnt_reg;
    logic [4:0] step_reg;
    logic [1:0] round_reg;
    logic toneOn_reg;
    logic toneHigh_reg;
    logic phaseEnd;
    logic [4:0] beeps;
    assign phaseEnd = (phaseCnt_reg == 28'h0000000);
    assign beeps = (pat_reg == BPI_PAT_VIDEO) ? 5'(VIDEO_BEEPS) : 5'(MEMORY_BEEPS);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pat_reg <= BPI_PAT_IDLE;
            phaseCnt_reg <= 28'h0000000;
            step_reg <= 5'h00;
            round_reg <= 2'h0;
            toneOn_reg <= 1'b0;
            toneHigh_reg <= 1'b0;
            powerLed <= 1'b0;
            shutdownReq <= 1'b0;
        end else if (request.thermalTrip) begin
            pat_reg <= BPI_PAT_THERMAL;
            phaseCnt_reg <= BLINK_CYC - 28'h0000001;
            step_reg <= 5'h00;
            toneOn_reg <= 1'b1;
            toneHigh_reg <= 1'b1;
            powerLed <= 1'b1;
        end else if (pat_reg != BPI_PAT_THERMAL && (request.memoryFault || request.videoFault)) begin
            pat_reg <= request.memoryFault ? BPI_PAT_MEMORY : BPI_PAT_VIDEO;
            phaseCnt_reg <= PULSE_CYC - 28'h0000001;
            step_reg <= 5'h00;
            round_reg <= 2'h0;
            toneOn_reg <= 1'b1;
            toneHigh_reg <= 1'b0;
            powerLed <= 1'b1;
        end else if (pat_reg == BPI_PAT_IDLE && request.updateStart) begin
            pat_reg <= BPI_PAT_UPDATE;
            phaseCnt_reg <= UPDATE_CYC - 28'h0000001;
            toneOn_reg <= 1'b0;
            powerLed <= 1'b0;
        end else if (pat_reg == BPI_PAT_IDLE && request.prompt) begin
            pat_reg <= BPI_PAT_PROMPT;
            phaseCnt_reg <= PROMPT_CYC - 28'h0000001;
            toneOn_reg <= 1'b1;
            toneHigh_reg <= 1'b0;
        end else begin
            if (!phaseEnd) begin
                phaseCnt_reg <= phaseCnt_reg - 28'h0000001;
            end
            case (pat_reg)
                BPI_PAT_PROMPT: begin
                    if (phaseEnd) begin
                        toneOn_reg <= 1'b0;
                        pat_reg <= BPI_PAT_IDLE;
                    end
                end
                BPI_PAT_UPDATE: begin
                    if (request.updateDone) begin
                        pat_reg <= BPI_PAT_IDLE;
                        powerLed <= 1'b0;
                    end else if (phaseEnd) begin
                        powerLed <= ~powerLed;
                        phaseCnt_reg <= UPDATE_CYC - 28'h0000001;
                    end
                end
                BPI_PAT_VIDEO, BPI_PAT_MEMORY: begin
                    if (phaseEnd) begin
                        // Even steps are on-phases, odd steps off-phases, the last step the pause.
                        if (step_reg == 5'(beeps * 5'h02)) begin
                            step_reg <= 5'h00;
                            phaseCnt_reg <= PULSE_CYC - 28'h0000001;
                            powerLed <= 1'b1;
                            if (round_reg != 2'h3) begin
                                round_reg <= round_reg + 2'h1;
                            end
                            // The round count saturates, so the old count is tested to keep video quiet for good.
                            toneOn_reg <= (pat_reg == BPI_PAT_MEMORY)
                                || (round_reg < 2'(VIDEO_TONE_ROUNDS - 1));
                        end else if (step_reg == 5'(beeps * 5'h02 - 5'h01)) begin
                            step_reg <= step_reg + 5'h01;
                            phaseCnt_reg <= PAUSE_CYC - 28'h0000001;
                            powerLed <= 1'b0;
                            toneOn_reg <= 1'b0;
                        end else begin
                            step_reg <= step_reg + 5'h01;
                            phaseCnt_reg <= PULSE_CYC - 28'h0000001;
                            powerLed <= step_reg[0];
                            toneOn_reg <= step_reg[0] && ((pat_reg == BPI_PAT_MEMORY)
                                || (round_reg < 2'(VIDEO_TONE_ROUNDS)));
                        end
                    end
                end
                BPI_PAT_THERMAL: begin
                    if (phaseEnd) begin
                        phaseCnt_reg <= BLINK_CYC - 28'h0000001;
                        powerLed <= ~powerLed;
                        if (step_reg[1:0] == 2'h3) begin
                            if (step_reg[4:2] == 3'(THERMAL_TONES - 1)) begin
                                pat_reg <= BPI_PAT_IDLE;
                                toneOn_reg <= 1'b0;
                                powerLed <= 1'b0;
                                shutdownReq <= 1'b1;
                            end else begin
                                toneHigh_reg <= ~toneHigh_reg;
                            end
                        end
                        step_reg <= step_reg + 5'h01;
                    end
                end
                default: begin
                    toneOn_reg <= 1'b0;
                end
            endcase
        end
    end

    logic [15:0] toneCnt_reg;
    logic [15:0] halfLimit;
    assign halfLimit = (pat_reg == BPI_PAT_THERMAL) ? (toneHigh_reg ? HIGH_HALF : LOW_HALF) : MAIN_HALF;

    // Square wave: the speaker toggles every half period of the chosen tone.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            toneCnt_reg <= 16'h0000;
            speaker <= 1'b0;
        end else if (!toneOn_reg) begin
            toneCnt_reg <= 16'h0000;
            speaker <= 1'b0;
        end else if (toneCnt_reg >= halfLimit - 16'h0001) begin
            toneCnt_reg <= 16'h0000;
            speaker <= ~speaker;
        end else begin
            toneCnt_reg <= toneCnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            patternBusy <= 1'b0;
        end else begin
            patternBusy <= (pat_reg != BPI_PAT_IDLE);
        end
    end

    property p_latch;
        @(posedge clk) disable iff (rst) (ioWrite && hit) |=> (code_reg == $past(ioWdata));
    endproperty
    a_latch: assert property (p_latch) else $error("Progress code not latched.");

    property p_hold;
        @(posedge clk) disable iff (rst) !(ioWrite && hit) |=> $stable(code_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("Progress code changed without a write.");

    property p_seg;
        @(posedge clk) disable iff (rst) !$past(rst) |=> display.segLow == hex_to_seg($past(code_reg[3:0]));
    endproperty
    a_seg: assert property (p_seg) else $error("Low digit segments wrong.");

    property p_cat;
        @(posedge clk) disable iff (rst) (code_reg[7:4] == 4'h4) |=> category == BPI_CAT_RESERVED;
    endproperty
    a_cat: assert property (p_cat) else $error("Reserved range not classified.");

    property p_fatal;
        @(posedge clk) disable iff (rst) (code_reg == 8'h2F) |=> fatalError;
    endproperty
    a_fatal: assert property (p_fatal) else $error("Memory fatal code not flagged.");

    property p_misc;
        @(posedge clk) disable iff (rst) (code_reg == 8'hEE) |=> !fatalError && !bootFail;
    endproperty
    a_misc: assert property (p_misc) else $error("Benign misc code flagged.");

    property p_thermal;
        @(posedge clk) disable iff (rst) request.thermalTrip |=> pat_reg == BPI_PAT_THERMAL && powerLed;
    endproperty
    a_thermal: assert property (p_thermal) else $error("Thermal did not pre-empt.");

    property p_update_quiet;
        @(posedge clk) disable iff (rst) (pat_reg == BPI_PAT_UPDATE) |=> !speaker;
    endproperty
    a_update_quiet: assert property (p_update_quiet) else $error("Speaker active during update.");

    property p_prompt;
        @(posedge clk) disable iff (rst) (pat_reg == BPI_PAT_IDLE && request.prompt && !request.thermalTrip
            && !request.memoryFault && !request.videoFault && !request.updateStart) |=> toneOn_reg [*8];
    endproperty
    a_prompt: assert property (p_prompt) else $error("Prompt tone not started.");
endmodule

/* File: testbench/bpi_host_model.sv */
// Host-side model: firmware that writes progress codes and raises indication requests.
// Assumes the indicator samples every strobe on the rising edge of clk.
`timescale 1ns/100ps
module bpi_host_model
    import bpi_pkg::*;
#(
    parameter bit HAS_GRAPHICS = 1'b0
) (
    input wire logic clk,
    input wire logic [7:0] ioRdata,
    output logic ioWrite,
    output logic ioRead,
    output logic [15:0] ioAddr,
    output logic [7:0] ioWdata,
    output bpi_request_t request
);
    initial begin
        ioWrite = 1'b0;
        ioRead = 1'b0;
        ioAddr = 16'h0000;
        ioWdata = 8'h00;
        request = '0;
    end

    // Released lines show the inverse of their last value, so a stale address cannot pass unnoticed.
    task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
        @(posedge clk);
        ioWrite <= 1'b1;
        ioAddr <= addr;
        ioWdata <= data;
        @(posedge clk);
        ioWrite <= 1'b0;
        ioAddr <= ~addr;
        ioWdata <= ~data;
    endtask

    task automatic io_read(input logic [15:0] addr, output logic [7:0] data);
        @(posedge clk);
        ioRead <= 1'b1;
        ioAddr <= addr;
        @(posedge clk);
        ioRead <= 1'b0;
        ioAddr <= ~addr;
        @(posedge clk);
        data = ioRdata;
    endtask

    task automatic raise(input bpi_request_t r);
        bpi_request_t q;
        q = r;
        q.videoFault = r.videoFault && !HAS_GRAPHICS;
        @(posedge clk);
        request <= q;
        @(posedge clk);
        request <= '0;
    endtask
endmodule

/* File: testbench/bpi_indicator_tb_top.sv */
// Testbench for the indicator: code latch, classifier, display and timed patterns.
// Assumes the host model drives all bus and request inputs; time is scaled by CLK_RATE.
`timescale 1ns/100ps
module bpi_indicator_tb_top
    import bpi_pkg::*;
;
    // A scaled clock rate keeps the run short; 4000 is the lowest that keeps every tone half period nonzero.
    localparam int SEC = 4000;
    localparam int HALF = SEC / (2 * TONE_MAIN_HZ);
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ioWrite, ioRead;
    logic [15:0] ioAddr;
    logic [7:0] ioWdata, ioRdata, heldCode, rd;
    bpi_request_t request;
    bpi_display_t display;
    bpi_category_t category;
    logic fatalError, bootFail, cpuException, speaker, powerLed, shutdownReq, patternBusy;
    int err_count = 0;
    int checks_done = 0;
    int ledOn, ledRise, spkTgl;
    logic [6:0] seg [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
        7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
    bpi_category_t expCat [16] = '{BPI_CAT_DEBUG, BPI_CAT_CPU, BPI_CAT_MEMORY, BPI_CAT_RECOVERY,
        BPI_CAT_RESERVED, BPI_CAT_BUS, BPI_CAT_RESERVED, BPI_CAT_OUTPUT, BPI_CAT_RESERVED, BPI_CAT_INPUT,
        BPI_CAT_RESERVED, BPI_CAT_BOOT_MEDIA, BPI_CAT_RESERVED, BPI_CAT_BOOT_SELECT, BPI_CAT_MISC, BPI_CAT_MISC};
    logic [15:0] fatalMask = 16'h0AAE;

    always #12.5 clk = ~clk;

    bpi_host_model u_host (.clk(clk), .ioRdata(ioRdata), .ioWrite(ioWrite), .ioRead(ioRead),
        .ioAddr(ioAddr), .ioWdata(ioWdata), .request(request));

    bpi_indicator #(.CLK_RATE(SEC)) dut (.clk(clk), .rst(rst), .ioWrite(ioWrite), .ioRead(ioRead),
        .ioAddr(ioAddr), .ioWdata(ioWdata), .request(request), .ioRdata(ioRdata), .heldCode(heldCode),
        .display(display), .category(category), .fatalError(fatalError), .bootFail(bootFail),
        .cpuException(cpuException), .speaker(speaker), .powerLed(powerLed), .shutdownReq(shutdownReq),
        .patternBusy(patternBusy));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Pattern edges may lag a cycle or two, and tone periods round down, so counts get a margin.
    task automatic near(input int got, input int exp);
        checks_done++;
        if (got > exp + exp / 50 + 8 || got < exp - exp / 50 - 8) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic measure(input int n);
        logic prevSpk, prevLed;
        ledOn = 0;
        ledRise = 0;
        spkTgl = 0;
        prevSpk = speaker;
        prevLed = powerLed;
        repeat (n) begin
            @(posedge clk);
            ledOn += int'(powerLed === 1'b1);
            ledRise += int'(powerLed === 1'b1 && prevLed === 1'b0);
            spkTgl += int'(speaker !== prevSpk);
            prevSpk = speaker;
            prevLed = powerLed;
        end
    endtask

    task automatic wr_check(input logic [7:0] c);
        u_host.io_write(PROGRESS_PORT_ADDR, c);
        repeat (3) @(posedge clk);
        chk(16'(heldCode), 16'(c));
        chk(16'(display), 16'({seg[c[7:4]], seg[c[3:0]]}));
        chk(16'(category), 16'(expCat[c[7:4]]));
        if (c[7:4] < 4'hE) chk(16'(fatalError), 16'(c[3:0] == 4'hF && fatalMask[c[7:4]]));
        chk(16'(bootFail), 16'(c == CODE_BOOT_FAIL));
        chk(16'(cpuException), 16'(c == CODE_CPU_EXCEPTION));
    endtask

    task automatic end_of_test;
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // The scenarios below take a little over 100000 cycles; the limit leaves a small margin.
    initial begin
        repeat (105000) @(posedge clk);
        err_count++;
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(16'(heldCode), 16'(PROGRESS_RESET));
        chk(16'({speaker, powerLed, shutdownReq}), 16'h0000);
        for (int n = 0; n < 32; n++) wr_check({4'(n / 2), (n % 2) ? 4'hF : 4'h0});
        wr_check(8'hEE);
        wr_check(8'hFF);
        u_host.io_write(16'h0081, 8'h5A);
        repeat (3) @(posedge clk);
        chk(16'(heldCode), 16'h00FF);
        u_host.io_read(PROGRESS_PORT_ADDR, rd);
        chk(16'(rd), 16'h00FF);
        u_host.io_write(PROGRESS_PORT_ADDR, 8'h3C);
        u_host.io_read(16'h0081, rd);
        chk(16'(rd), 16'h00FF);
        u_host.raise(6'b100000);
        measure(SEC / 2 + 8);
        near(spkTgl, SEC / 2 / HALF);
        measure(SEC / 8);
        near(spkTgl, 0);
        u_host.raise(6'b010000);
        measure(SEC);
        near(ledOn, SEC / 2);
        near(ledRise, 1);
        near(spkTgl, 0);
        u_host.raise(6'b001000);
        measure(8);
        chk(16'(patternBusy), 16'h0000);
        u_host.raise(6'b000100);
        for (int r = 0; r < 2; r++) begin
            measure(SEC * 13 / 2);
            near(ledOn, 2 * SEC);
            near(ledRise, 2);
            near(spkTgl, 2 * SEC / HALF);
        end
        measure(SEC / 8);
        near(ledOn, SEC / 8);
        near(spkTgl, 0);
        // The LED is already lit here, so the restarted memory blink adds no rising edge at first.
        u_host.raise(6'b000010);
        measure(SEC * 17 / 8);
        near(ledOn, SEC * 9 / 8);
        near(ledRise, 1);
        near(spkTgl, SEC * 9 / 8 / HALF);
        // Thermal and memory arrive together; thermal must win.
        u_host.raise(6'b000011);
        measure(8 * SEC);
        near(ledOn, 4 * SEC);
        near(ledRise, 15);
        near(spkTgl, 4 * SEC / (SEC / (2 * TONE_HIGH_HZ)) + 4 * SEC / (SEC / (2 * TONE_LOW_HZ)));
        measure(SEC / 8);
        near(ledOn + spkTgl, 0);
        chk(16'({shutdownReq, patternBusy}), 16'h0002);
        // A reset in mid-run must drop the sticky shutdown request and the held code.
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(16'({heldCode, shutdownReq, patternBusy}), 16'h0000);
        wr_check(8'h2F);
        end_of_test();
    end
endmodule
